// ### fexec_defines.svh
// Constants for the invert and equal-skip execution block
`ifndef FEXEC_DEFINES_SVH
`define FEXEC_DEFINES_SVH
`define OPC_HI_W 6
`define INVERT_OPC_HI 6'h07
`define EQSKIP_OPC_HI 7'h31
`define DEST_BIT 9
`define BANK_MODE_BIT 8
`define ACCESS_BANK 4'h0
`define TWO_WORD_OPC 4'hf
`define MEM_DEPTH 4096
`define MEM_AW 12
`endif

// ### fexec_pkg.sv
// Types for the invert and equal-skip execution block
package fexec_pkg;
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_t;
   typedef enum logic [1:0] {RUN, SKIP1, SKIP2} skip_t;
   typedef struct packed {
      logic neg;
      logic zero;
   } flags_t;
endpackage

// ### fexec_mem.sv
// Banked data memory with registered read port
`timescale 1ns/10ps
`default_nettype none
module fexec_mem (
   input wire logic clk_in,             // Core clock
   input wire logic [11:0] raddr_in,    // Read address
   output logic [7:0] rdata_out,        // Registered read data
   input wire logic we_in,              // Write strobe
   input wire logic [11:0] waddr_in,    // Write address
   input wire logic [7:0] wdata_in      // Write data
);
   // Contents start at zero so a first read of any file register is defined
   logic [7:0] mem_r [0:4095] = '{default: 8'h00};
   // Read data always registered, one phase latency
   always_ff @(posedge clk_in) begin
      rdata_out <= mem_r[raddr_in];
   end
   // Write port
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_r[waddr_in] <= wdata_in;
      end
   end
endmodule // fexec_mem
`default_nettype wire

// ### fexec_core.sv
// Execution of the invert-file and compare-skip-if-equal instructions
// Behaviour
// - Invert op reads register, result is its inverse
// - Dest 0 to accumulator, 1 back to register
// - Bank-mode 0 forces access bank, else pointer
// - Equal-skip compares unsigned, no flags, no store
// - Decode equal-skip by upper seven opcode bits only, not a or address
// - Equal values discard next word, run nop
// - Two-word skipped instruction costs three cycles total
// - Equal-skip is one word, one cycle unskipped
`timescale 1ns/10ps
`default_nettype none
`include "fexec_defines.svh"
module fexec_core (
   input wire logic clk_in,                 // Core clock, 10 MHz, one phase per edge
   input wire logic rst_n_in,               // Synchronous reset, active low
   input wire logic [15:0] instr_in,        // Instruction word latched at Q1
   input wire logic [3:0] bank_pointer_in,  // Bank pointer
   input wire logic [7:0] acc_in,           // Accumulator value
   output logic [1:0] phase_out,            // Current phase Q1..Q4
   output logic acc_we_out,                 // Accumulator write strobe
   output logic [7:0] acc_wdata_out,        // Accumulator write data
   output logic flags_we_out,               // Flag write strobe
   output fexec_pkg::flags_t flags_out,     // N and Z values
   output logic skip_out,                   // High while a word executes as nop
   output logic [7:0] result_out            // Last computed result
);
   fexec_pkg::phase_t phase_r;
   fexec_pkg::skip_t skip_r;
   logic [15:0] ir_r;
   logic [7:0] res_r;
   logic [7:0] rdata;
   logic [11:0] addr;
   logic is_inv, is_eq, mem_we, two_word;
   logic [8:0] diff;

   // Decode from the held word; a skipped word decodes as nothing
   assign is_inv = (ir_r[15:10] == `INVERT_OPC_HI) && (skip_r == fexec_pkg::RUN);
   assign is_eq = (ir_r[15:9] == `EQSKIP_OPC_HI) && (skip_r == fexec_pkg::RUN);
   // Bank select: access bank overrides the pointer when a is clear
   assign addr = ir_r[`BANK_MODE_BIT] ? {bank_pointer_in, ir_r[7:0]}
                                      : {`ACCESS_BANK, ir_r[7:0]};
   // Subtraction only feeds the equality test, nothing stored
   assign diff = {1'b0, rdata} - {1'b0, acc_in};
   // Two-word instructions are those whose first word starts with 1111 or 1100/1110 long forms
   // Judged from the held word, so a change on the input pins after Q1 cannot stretch a skip
   assign two_word = (ir_r[15:12] == `TWO_WORD_OPC) ||
                     (ir_r[15:9] == 7'h76) || (ir_r[15:8] == 8'hec) ||
                     (ir_r[15:8] == 8'hef) || (ir_r[15:12] == 4'hc);

   fexec_mem i_fexec_mem (
      .clk_in(clk_in),
      .raddr_in(addr),
      .rdata_out(rdata),
      .we_in(mem_we),
      .waddr_in(addr),
      .wdata_in(res_r)
   );

   // Phase sequencer, one instruction cycle is four edges
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         phase_r <= fexec_pkg::Q1;
      end else begin
         unique case (phase_r)
            fexec_pkg::Q1: phase_r <= fexec_pkg::Q2;
            fexec_pkg::Q2: phase_r <= fexec_pkg::Q3;
            fexec_pkg::Q3: phase_r <= fexec_pkg::Q4;
            fexec_pkg::Q4: phase_r <= fexec_pkg::Q1;
         endcase
      end
   end

   // Instruction hold, captured in Q1 decode
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ir_r <= 16'h0000;
      end else if (phase_r == fexec_pkg::Q1) begin
         ir_r <= instr_in;
      end
   end

   // Processing in Q3: invert the read value
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         res_r <= 8'h00;
      end else if (phase_r == fexec_pkg::Q3 && is_inv) begin
         res_r <= ~rdata;
      end
   end

   // Skip state: next word, and its second word if long, run as nop
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         skip_r <= fexec_pkg::RUN;
      end else if (phase_r == fexec_pkg::Q4) begin
         unique case (skip_r)
            fexec_pkg::RUN: skip_r <= (is_eq && diff == 9'h000) ? fexec_pkg::SKIP1
                                                                : fexec_pkg::RUN;
            fexec_pkg::SKIP1: skip_r <= two_word ? fexec_pkg::SKIP2 : fexec_pkg::RUN;
            fexec_pkg::SKIP2: skip_r <= fexec_pkg::RUN;
            default: skip_r <= fexec_pkg::RUN; // Unused code 3 falls back to normal running
         endcase
      end
   end
   // Note: two_word is judged from the skipped word held in ir_r during its own Q4

   // Q4 write to destination
   assign mem_we = (phase_r == fexec_pkg::Q4) && is_inv && ir_r[`DEST_BIT];
   assign acc_we_out = (phase_r == fexec_pkg::Q4) && is_inv && !ir_r[`DEST_BIT];
   assign acc_wdata_out = res_r;
   assign flags_we_out = (phase_r == fexec_pkg::Q4) && is_inv;
   assign flags_out.neg = res_r[7];
   assign flags_out.zero = (res_r == 8'h00);
   assign phase_out = phase_r;
   assign skip_out = (skip_r != fexec_pkg::RUN);
   assign result_out = res_r;

   // Helper: inverted value lands in Q4 of same cycle
   property p_inv_result;
      @(posedge clk_in) disable iff (!rst_n_in)
         (phase_r == fexec_pkg::Q3 && is_inv) |=> (res_r == ~$past(rdata));
   endproperty
   a_inv_result: assert property (p_inv_result) else $error("invert result wrong");

   property p_dest_acc;
      @(posedge clk_in) disable iff (!rst_n_in)
         acc_we_out |-> (!ir_r[`DEST_BIT] && !mem_we);
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("bad destination");

   property p_bank;
      @(posedge clk_in) disable iff (!rst_n_in)
         !ir_r[`BANK_MODE_BIT] |-> (addr[11:8] == `ACCESS_BANK);
   endproperty
   a_bank: assert property (p_bank) else $error("access bank not forced");

   property p_eq_noflags;
      @(posedge clk_in) disable iff (!rst_n_in)
         is_eq |-> !flags_we_out && !mem_we && !acc_we_out;
   endproperty
   a_eq_noflags: assert property (p_eq_noflags) else $error("compare changed state");

   sequence s_eq_hit;
      phase_r == fexec_pkg::Q4 && is_eq && diff == 9'h000;
   endsequence
   property p_skip;
      @(posedge clk_in) disable iff (!rst_n_in)
         s_eq_hit |=> skip_out [*4];
   endproperty
   a_skip: assert property (p_skip) else $error("skip not taken");

   property p_noskip;
      @(posedge clk_in) disable iff (!rst_n_in)
         (phase_r == fexec_pkg::Q4 && is_eq && diff != 9'h000) |=> !skip_out;
   endproperty
   a_noskip: assert property (p_noskip) else $error("spurious skip");

   property p_two_word;
      @(posedge clk_in) disable iff (!rst_n_in)
         (phase_r == fexec_pkg::Q4 && skip_r == fexec_pkg::SKIP1 && two_word)
            |=> skip_out [*4] ##1 !skip_out;
   endproperty
   a_two_word: assert property (p_two_word) else $error("second word not skipped");

   property p_flags;
      @(posedge clk_in) disable iff (!rst_n_in)
         flags_we_out |-> (flags_out.zero == (res_r == 8'h00)) && (phase_r == fexec_pkg::Q4);
   endproperty
   a_flags: assert property (p_flags) else $error("flag update wrong");

   // Accumulator data is the inverse of the value read in Q3
   property p_acc_data;
      @(posedge clk_in) disable iff (!rst_n_in)
         acc_we_out |-> (acc_wdata_out == ~$past(rdata));
   endproperty
   a_acc_data: assert property (p_acc_data) else $error("accumulator data wrong");

   // A word run as nop must leave every destination and flag alone
   property p_skip_quiet;
      @(posedge clk_in) disable iff (!rst_n_in)
         skip_out |-> (!acc_we_out && !flags_we_out && !mem_we);
   endproperty
   a_skip_quiet: assert property (p_skip_quiet) else $error("skipped word had effect");

   // Invert issued at Q1 writes its flags three phases later, within one cycle
   sequence s_inv_issue;
      phase_r == fexec_pkg::Q1 && instr_in[15:10] == `INVERT_OPC_HI && skip_r == fexec_pkg::RUN;
   endsequence
   property p_inv_cycle;
      @(posedge clk_in) disable iff (!rst_n_in)
         s_inv_issue |-> ##3 flags_we_out;
   endproperty
   a_inv_cycle: assert property (p_inv_cycle) else $error("invert not done in one cycle");

   // Four phases make one instruction cycle, then decode starts again
   property p_phase_wrap;
      @(posedge clk_in) disable iff (!rst_n_in)
         (phase_r == fexec_pkg::Q4) |=> (phase_r == fexec_pkg::Q1);
   endproperty
   a_phase_wrap: assert property (p_phase_wrap) else $error("phase order broken");

   // With bank mode set, the pointer supplies the upper address bits
   property p_bank_pointer;
      @(posedge clk_in) disable iff (!rst_n_in)
         ir_r[`BANK_MODE_BIT] |-> (addr == {bank_pointer_in, ir_r[7:0]});
   endproperty
   a_bank_pointer: assert property (p_bank_pointer) else $error("bank pointer ignored");
endmodule // fexec_core
`default_nettype wire

// ### complement_and_compare_skip_exec_bench.sv
// Self-checking bench for the invert and equal-skip execution core
`timescale 1ns/10ps
`default_nettype none
module complement_and_compare_skip_exec_bench;
   logic clk_in;
   logic rst_n_in;
   logic [15:0] instr_in;
   logic [3:0] bank_pointer_in;
   logic [7:0] acc_in;
   logic [1:0] phase_out;
   logic acc_we_out;
   logic [7:0] acc_wdata_out;
   logic flags_we_out;
   fexec_pkg::flags_t flags_out;
   logic skip_out;
   logic [7:0] result_out;
   int error_cnt;
   int num_checks;

   fexec_core i_fexec_core (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .instr_in(instr_in),
      .bank_pointer_in(bank_pointer_in),
      .acc_in(acc_in),
      .phase_out(phase_out),
      .acc_we_out(acc_we_out),
      .acc_wdata_out(acc_wdata_out),
      .flags_we_out(flags_we_out),
      .flags_out(flags_out),
      .skip_out(skip_out),
      .result_out(result_out)
   );

   // 10 MHz core clock
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // Case equality so an unknown never passes
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Memory is not reset, so only state that reset defines is compared
   task automatic check_reset;
      check("phase", {6'h00, phase_out}, 8'h00);
      check("skip", {7'h00, skip_out}, 8'h00);
      check("result", result_out, 8'h00);
      check("flags", {6'h00, flags_out}, 8'h01);
   endtask

   // Issues one word at Q1 and watches strobes and skip through all four phases, result at Q4
   task automatic run_word(input logic [15:0] word, input logic [3:0] bank, input logic exp_acc,
                           input logic exp_flg, input logic exp_skip, input logic [7:0] exp_res);
      int k;
      int n;
      for (n = 0; n < 8 && phase_out !== 2'h0; n++) begin
         @(posedge clk_in);
         #1;
      end
      instr_in = word;
      bank_pointer_in = bank;
      for (k = 0; k < 4; k++) begin
         check("phase", {6'h00, phase_out}, {6'h00, k[1:0]});
         check("acc_we", {7'h00, acc_we_out}, {7'h00, exp_acc && k == 3});
         check("flags_we", {7'h00, flags_we_out}, {7'h00, exp_flg && k == 3});
         check("skip", {7'h00, skip_out}, {7'h00, exp_skip});
         // Result lands after Q3, so Q4 is the first phase where it stands
         if (k == 3) begin
            check("result", result_out, exp_res);
            check("acc_wdata", acc_wdata_out, exp_res);
            check("flags", {6'h00, flags_out}, {6'h00, exp_res[7], exp_res == 8'h00});
         end
         @(posedge clk_in);
         #1;
      end
   endtask

   // Main sequence; memory starts at zero, so each expectation follows from earlier words
   initial begin
      error_cnt = 0;
      num_checks = 0;
      rst_n_in = 1'b0;
      instr_in = 16'h0000;
      bank_pointer_in = 4'h0;
      acc_in = 8'h5a;
      repeat (16) @(posedge clk_in);
      #1;
      check_reset();
      rst_n_in = 1'b1;
      run_word(16'h1c05, 4'h3, 1'b1, 1'b1, 1'b0, 8'hff); // To accumulator, access bank
      run_word(16'h1f20, 4'h5, 1'b0, 1'b1, 1'b0, 8'hff); // Back to register 520
      run_word(16'h1d20, 4'h5, 1'b1, 1'b1, 1'b0, 8'h00); // Reads stored ff, zero flag
      run_word(16'h1e7f, 4'h1, 1'b0, 1'b1, 1'b0, 8'hff); // To register 07f, pointer ignored
      run_word(16'h0000, 4'h0, 1'b0, 1'b0, 1'b0, 8'hff); // Other opcode, result holds
      run_word(16'h6205, 4'h3, 1'b0, 1'b0, 1'b0, 8'hff); // Equal-skip miss, 00 against 5a
      acc_in = 8'hff;
      run_word(16'h6320, 4'h5, 1'b0, 1'b0, 1'b0, 8'hff); // Hit on 520; no skip after a miss
      run_word(16'h1d20, 4'h5, 1'b0, 1'b0, 1'b1, 8'hff); // Skipped invert leaves result alone
      run_word(16'h627f, 4'h3, 1'b0, 1'b0, 1'b0, 8'hff); // Hit via access bank 07f
      run_word(16'hef00, 4'h0, 1'b0, 1'b0, 1'b1, 8'hff); // Skipped first of two words
      run_word(16'h1d20, 4'h5, 1'b0, 1'b0, 1'b1, 8'hff); // Its second word is a nop too
      run_word(16'h1d20, 4'h5, 1'b1, 1'b1, 1'b0, 8'h00); // Runs again after three cycles
      acc_in = 8'h00;
      run_word(16'h6205, 4'h3, 1'b0, 1'b0, 1'b0, 8'h00); // Hit on zero location
      // Reset lands inside the skip that the hit above started
      rst_n_in = 1'b0;
      @(posedge clk_in);
      #1;
      check_reset();
      rst_n_in = 1'b1;
      run_word(16'h1cff, 4'h7, 1'b1, 1'b1, 1'b0, 8'hff); // After mid-run reset, no skip
      wrap_up();
   end

   // Watchdog well past the expected run of about 73 clock cycles
   initial begin
      repeat (2000) @(posedge clk_in);
      error_cnt++;
      wrap_up();
   end
endmodule // complement_and_compare_skip_exec_bench
`default_nettype wire
